// ===== hss_pkg.sv
package hss_pkg;

  localparam int AXI_ADDR_W = 6;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_GLOBAL = 4'h1;
  localparam logic [3:0] IDX_PLL    = 4'h2;
  localparam logic [3:0] IDX_TXRX   = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h4;

  localparam logic [15:0] GLOBAL_RST = 16'h0000;
  localparam logic [15:0] PLL_RST    = 16'h811d;
  localparam logic [15:0] TXRX_RST   = 16'ha444;
  localparam logic [15:0] GLOBAL_WMASK = 16'h8000;

  localparam int GPD_BIT    = 15;
  localparam int LBW_LO     = 8;
  localparam int VCO_BIT    = 6;
  localparam int PLLEN_BIT  = 4;
  localparam int MULT_LO    = 0;
  localparam int SWING_LO   = 12;
  localparam int TXEN_BIT   = 10;
  localparam int RATE_LO    = 8;

  localparam logic [1:0] LBW_NO_JC = 2'h1;
  localparam logic [1:0] LBW_JC    = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // decoded serdes settings driven toward the analog macro
  typedef struct packed {
    logic       pll_en;
    logic       tx_en;
    logic [1:0] loop_bw;
    logic       lbw_rsvd;
    logic       vco_low;
    logic [3:0] mult;
    logic [6:0] mult_x4;
    logic       mult_rsvd;
    logic [3:0] swing;
    logic [1:0] rate;
    logic [3:0] rate_div;
  } hss_ctl_s;

  typedef struct packed {
    logic                  aw_got;
    logic                  w_got;
    logic [3:0]            aw_idx;
    logic [15:0]           wdata;
    logic [1:0]            wstrb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic [15:0]           global_reg;
    logic [15:0]           pll_reg;
    logic [15:0]           txrx_reg;
    logic                  pd_meta;
    logic                  pd_sync;
    hss_ctl_s              ctl;
  } hss_state_s;

endpackage : hss_pkg

// ===== hss_mult_dec.sv
`timescale 1ns/1ps
// multiplier code to factor in quarter steps, so 8.25x and 16.5x stay integral
module hss_mult_dec
  import hss_pkg::*;
(
  input  wire logic [3:0] code_in,
  output logic      [6:0] factor_x4_out,
  output logic            rsvd_out
);
  always_comb begin
    rsvd_out = 1'b0;
    case (code_in)
      4'h2:    factor_x4_out = 7'h10;
      4'h3:    factor_x4_out = 7'h14;
      4'h4:    factor_x4_out = 7'h18;
      4'h5:    factor_x4_out = 7'h20;
      4'h6:    factor_x4_out = 7'h21;
      4'h7:    factor_x4_out = 7'h28;
      4'h8:    factor_x4_out = 7'h30;
      4'h9:    factor_x4_out = 7'h32;
      4'ha:    factor_x4_out = 7'h3c;
      4'hb:    factor_x4_out = 7'h40;
      4'hc:    factor_x4_out = 7'h42;
      4'hd:    factor_x4_out = 7'h50;
      4'he:    factor_x4_out = 7'h64;
      default: begin
        factor_x4_out = 7'h00;
        rsvd_out      = 1'b1;
      end
    endcase
  end
endmodule : hss_mult_dec

// ===== hss_regs.sv
`timescale 1ns/1ps
// How it works
// - loop bandwidth field resets to 01, 10 for external cleaner, 00/11 reserved
// - pll enable resets to 1; forced off by power-down pin low or global bit
// - multiplier code decodes to thirteen factors; 0000, 0001, 1111 reserved; reset 1101
// - transmit swing is four-bit field at bits 15:12 of second register, reset 1010
// - transmit enable resets to 1; forced off by power-down pin low or global bit
// - transmit rate 00 full, 01 half, 10 quarter, 11 eighth; reset 00
// - registers reset to 0x811d and 0xa444, all fields read/write
module hss_regs
  import hss_pkg::*;
(
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  channel_powerdown_n_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  output hss_ctl_s                   serdes_ctl_out
);

  hss_state_s st_r;
  hss_state_s st_nxt;
  logic [6:0] dec_x4;
  logic       dec_rsvd;
  logic [3:0] ar_idx;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic [15:0] bytemask;

  assign ar_idx = s_axi_araddr_in[AXI_ADDR_W-1:2];

  hss_mult_dec u_mult_dec (
    .code_in       (st_nxt.pll_reg[MULT_LO+:4]),
    .factor_x4_out (dec_x4),
    .rsvd_out      (dec_rsvd)
  );

  always_comb begin
    st_nxt = st_r;
    rd_val = 16'h0000;
    rd_hit = 1'b1;
    bytemask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};

    // pin crosses two flops before anything looks at it
    st_nxt.pd_meta = channel_powerdown_n_in;
    st_nxt.pd_sync = st_r.pd_meta;

    // write address and data taken in either order
    if (s_axi_awvalid_in && st_r.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.awready = 1'b0;
      st_nxt.aw_idx  = s_axi_awaddr_in[AXI_ADDR_W-1:2];
    end
    if (s_axi_wvalid_in && st_r.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.wready = 1'b0;
      st_nxt.wdata  = s_axi_wdata_in[15:0];
      st_nxt.wstrb  = s_axi_wstrb_in[1:0];
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      case (st_r.aw_idx)
        IDX_GLOBAL: st_nxt.global_reg = (st_r.global_reg & ~(bytemask & GLOBAL_WMASK))
                                        | (st_r.wdata & bytemask & GLOBAL_WMASK);
        // every field stored as written, reserved codes included
        IDX_PLL:    st_nxt.pll_reg  = (st_r.pll_reg & ~bytemask) | (st_r.wdata & bytemask);
        IDX_TXRX:   st_nxt.txrx_reg = (st_r.txrx_reg & ~bytemask) | (st_r.wdata & bytemask);
        IDX_STATUS: st_nxt.bresp = RESP_OKAY;
        default:    st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // reads: one outstanding, data registered
    case (ar_idx)
      IDX_GLOBAL: rd_val = st_r.global_reg;
      IDX_PLL:    rd_val = st_r.pll_reg;
      IDX_TXRX:   rd_val = st_r.txrx_reg;
      IDX_STATUS: rd_val = {11'h000, st_r.ctl.lbw_rsvd, st_r.ctl.mult_rsvd, ~st_r.pd_sync,
                            st_r.ctl.tx_en, st_r.ctl.pll_en};
      default:    rd_hit = 1'b0;
    endcase
    if (s_axi_arvalid_in && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = {16'h0000, rd_val};
      st_nxt.rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // decoded settings follow the next register image so they move with it
    // only the second synchroniser flop may feed the enables, so the pin costs one more cycle
    st_nxt.ctl.pll_en    = st_nxt.pll_reg[PLLEN_BIT] & st_r.pd_sync
                           & ~st_nxt.global_reg[GPD_BIT];
    st_nxt.ctl.tx_en     = st_nxt.txrx_reg[TXEN_BIT] & st_r.pd_sync
                           & ~st_nxt.global_reg[GPD_BIT];
    st_nxt.ctl.loop_bw   = st_nxt.pll_reg[LBW_LO+:2];
    st_nxt.ctl.lbw_rsvd  = (st_nxt.ctl.loop_bw != LBW_NO_JC) && (st_nxt.ctl.loop_bw != LBW_JC);
    st_nxt.ctl.vco_low   = st_nxt.pll_reg[VCO_BIT];
    st_nxt.ctl.mult      = st_nxt.pll_reg[MULT_LO+:4];
    st_nxt.ctl.mult_x4   = dec_x4;
    st_nxt.ctl.mult_rsvd = dec_rsvd;
    st_nxt.ctl.swing     = st_nxt.txrx_reg[SWING_LO+:4];
    st_nxt.ctl.rate      = st_nxt.txrx_reg[RATE_LO+:2];
    st_nxt.ctl.rate_div  = 4'h1 << st_nxt.ctl.rate;

    if (!nrst_in) begin
      st_nxt = '0;
      st_nxt.awready    = 1'b1;
      st_nxt.wready     = 1'b1;
      st_nxt.arready    = 1'b1;
      st_nxt.global_reg = GLOBAL_RST;
      st_nxt.pll_reg    = PLL_RST;
      st_nxt.txrx_reg   = TXRX_RST;
      // enables stay off until the pin has been seen high through the synchroniser
      st_nxt.ctl.loop_bw  = PLL_RST[LBW_LO+:2];
      st_nxt.ctl.vco_low  = PLL_RST[VCO_BIT];
      st_nxt.ctl.mult     = PLL_RST[MULT_LO+:4];
      st_nxt.ctl.mult_x4  = 7'h50;
      st_nxt.ctl.swing    = TXRX_RST[SWING_LO+:4];
      st_nxt.ctl.rate     = TXRX_RST[RATE_LO+:2];
      st_nxt.ctl.rate_div = 4'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign s_axi_awready_out = st_r.awready;
  assign s_axi_wready_out  = st_r.wready;
  assign s_axi_bvalid_out  = st_r.bvalid;
  assign s_axi_bresp_out   = st_r.bresp;
  assign s_axi_arready_out = st_r.arready;
  assign s_axi_rvalid_out  = st_r.rvalid;
  assign s_axi_rresp_out   = st_r.rresp;
  assign s_axi_rdata_out   = st_r.rdata;
  assign serdes_ctl_out    = st_r.ctl;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_lbw_field;
    serdes_ctl_out.loop_bw == st_r.pll_reg[LBW_LO+:2]
    && (serdes_ctl_out.lbw_rsvd == (serdes_ctl_out.loop_bw[1] == serdes_ctl_out.loop_bw[0]));
  endproperty
  a_lbw_field: assert property (p_lbw_field) else $error("loop bandwidth mismatch");

  property p_pll_off;
    (!$past(st_r.pd_sync) || st_r.global_reg[GPD_BIT] || !st_r.pll_reg[PLLEN_BIT]) |-> !serdes_ctl_out.pll_en;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll enabled while forced off");

  property p_mult_dec;
    (serdes_ctl_out.mult == 4'hd |-> serdes_ctl_out.mult_x4 == 7'h50)
    and (serdes_ctl_out.mult == 4'h6 |-> serdes_ctl_out.mult_x4 == 7'h21)
    and (serdes_ctl_out.mult == 4'hf |-> serdes_ctl_out.mult_rsvd);
  endproperty
  a_mult_dec: assert property (p_mult_dec) else $error("multiplier decode wrong");

  property p_swing;
    serdes_ctl_out.swing == st_r.txrx_reg[SWING_LO+:4];
  endproperty
  a_swing: assert property (p_swing) else $error("swing not from bits 15:12");

  sequence s_pin_low;
    !$past(st_r.pd_sync);
  endsequence
  property p_tx_off;
    s_pin_low or (st_r.global_reg[GPD_BIT]) |-> !serdes_ctl_out.tx_en;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter on while forced off");

  property p_rate_div;
    serdes_ctl_out.rate_div == (4'h1 << serdes_ctl_out.rate);
  endproperty
  a_rate_div: assert property (p_rate_div) else $error("rate divisor wrong");

  property p_reset_vals;
    $rose(nrst_in) |-> st_r.pll_reg == PLL_RST && st_r.txrx_reg == TXRX_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

endmodule : hss_regs

// ===== hss_regs_tb.sv
`timescale 1ns/1ps
module hss_regs_tb
  import hss_pkg::*;
;
  localparam logic [5:0] A_GLB  = {IDX_GLOBAL, 2'b00};
  localparam logic [5:0] A_PLL  = {IDX_PLL, 2'b00};
  localparam logic [5:0] A_TXRX = {IDX_TXRX, 2'b00};
  localparam logic [5:0] A_STS  = {IDX_STATUS, 2'b00};
  localparam logic [5:0] A_BAD  = 6'h3c;
  logic                  core_clk_in = 1'b0;
  logic                  nrst_in     = 1'b0;
  logic                  pd_n        = 1'b1;
  logic [AXI_ADDR_W-1:0] awaddr      = '0;
  logic [AXI_ADDR_W-1:0] araddr      = '0;
  logic                  awvalid     = 1'b0;
  logic                  wvalid      = 1'b0;
  logic                  bready      = 1'b0;
  logic                  arvalid     = 1'b0;
  logic                  rready      = 1'b0;
  logic [31:0]           wdata       = '0;
  logic [3:0]            wstrb       = '0;
  logic                  awready;
  logic                  wready;
  logic                  bvalid;
  logic                  arready;
  logic                  rvalid;
  logic [1:0]            bresp;
  logic [1:0]            rresp;
  logic [31:0]           rdata;
  hss_ctl_s              ctl;
  logic [1:0]            resp;
  logic [31:0]           rd;
  int                    miscompares     = 0;
  int                    samples_checked = 0;
  // factor times four, reserved codes give zero
  logic [6:0]            mx4 [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18, 7'h20, 7'h21, 7'h28,
                                      7'h30, 7'h32, 7'h3c, 7'h40, 7'h42, 7'h50, 7'h64, 7'h00};

  always #20 core_clk_in = ~core_clk_in;

  hss_regs u_hss_regs (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .channel_powerdown_n_in(pd_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .serdes_ctl_out(ctl));

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic timeout();
    miscompares++;
    $display("[ERR] %0t bus answer never came", $time);
    report_and_stop();
  endtask : timeout

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : cyc

  // readies sampled before the edge's own updates land
  task automatic axi_write(input logic [5:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    @(posedge core_clk_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge core_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask : axi_write

  task automatic axi_read(input logic [5:0] a);
    @(posedge core_clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge core_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd   = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask : axi_read

  task automatic chk_en(input logic [1:0] exp);
    chk(32'({ctl.pll_en, ctl.tx_en}), 32'(exp));
  endtask : chk_en

  initial begin
    repeat (8) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    cyc(3);
    axi_read(A_PLL);
    chk(rd, 32'h0000811d);
    axi_read(A_TXRX);
    chk(rd, 32'h0000a444);
    // status: both enables on, pin high, no reserved codes
    axi_read(A_STS);
    chk(rd, 32'h00000003);
    chk_en(2'b11);
    chk(32'({ctl.loop_bw, ctl.mult, ctl.mult_x4}), 32'({2'h1, 4'hd, 7'h50}));
    chk(32'({ctl.swing, ctl.rate, ctl.rate_div}), 32'({4'ha, 2'h0, 4'h1}));
    for (int i = 0; i < 16; i++) begin
      axi_write(A_PLL, {PLL_RST[15:4], 4'(i)});
      chk(32'(resp), 32'(RESP_OKAY));
      chk(32'({ctl.mult_x4, ctl.mult_rsvd}), 32'({mx4[i], i < 2 || i == 15}));
    end
    for (int i = 0; i < 4; i++) begin
      axi_write(A_PLL, {PLL_RST[15:10], 2'(i), PLL_RST[7], i[0], PLL_RST[5:0]});
      chk(32'({ctl.loop_bw, ctl.lbw_rsvd}), 32'({2'(i), i == 0 || i == 3}));
      chk(32'(ctl.vco_low), 32'(i[0]));
      axi_write(A_TXRX, {4'(i * 5), TXRX_RST[11:10], 2'(i), TXRX_RST[7:0]});
      chk(32'({ctl.swing, ctl.rate, ctl.rate_div}), 32'({4'(i * 5), 2'(i), 4'(1 << i)}));
    end
    // every bit, reserved ones too, must hold what was written
    axi_write(A_PLL, 16'hffff);
    axi_write(A_TXRX, 16'hffff);
    axi_read(A_PLL);
    chk(rd, 32'h0000ffff);
    axi_read(A_TXRX);
    chk(rd, 32'h0000ffff);
    // upper byte strobe alone leaves the low byte untouched
    axi_write(A_PLL, 16'h0000, 4'h2);
    axi_read(A_PLL);
    chk(rd, 32'h000000ff);
    axi_write(A_PLL, PLL_RST & ~16'h0010);
    axi_write(A_TXRX, TXRX_RST);
    cyc(2);
    chk_en(2'b01);
    axi_write(A_TXRX, TXRX_RST & ~16'h0400);
    axi_write(A_PLL, PLL_RST);
    cyc(2);
    chk_en(2'b10);
    axi_write(A_TXRX, TXRX_RST);
    // only the global power-down bit is writable
    axi_write(A_GLB, 16'hffff);
    cyc(2);
    chk_en(2'b00);
    axi_read(A_GLB);
    chk(rd, 32'h00008000);
    axi_read(A_STS);
    chk(rd, 32'h00000000);
    axi_write(A_GLB, 16'h0000);
    cyc(2);
    chk_en(2'b11);
    pd_n <= 1'b0;
    cyc(3);
    chk_en(2'b00);
    axi_read(A_STS);
    chk(rd, 32'h00000004);
    pd_n <= 1'b1;
    cyc(3);
    chk_en(2'b11);
    axi_write(A_STS, 16'hffff);
    chk(32'(resp), 32'(RESP_OKAY));
    axi_write(A_BAD, 16'h1234);
    chk(32'(resp), 32'(RESP_SLVERR));
    axi_read(A_BAD);
    chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
    // second reset in mid-run must restore defaults
    axi_write(A_PLL, 16'h0000);
    nrst_in <= 1'b0;
    cyc(3);
    nrst_in <= 1'b1;
    cyc(3);
    axi_read(A_PLL);
    chk(rd, 32'h0000811d);
    chk_en(2'b11);
    report_and_stop();
  end
endmodule : hss_regs_tb
